// ===== msp_pkg.sv
// Shared constants for the meter parameter and output formatting block
package msp_pkg;
   // Register byte offsets
   localparam logic [7:0] MSP_ADDR_OFFSET = 8'h00;
   localparam logic [7:0] MSP_ADDR_FORMAT = 8'h04;
   localparam logic [7:0] MSP_ADDR_LINE = 8'h08;
   localparam logic [7:0] MSP_ADDR_CMD = 8'h0C;
   localparam logic [7:0] MSP_ADDR_MEAS = 8'h10;
   localparam logic [7:0] MSP_ADDR_EXTRA = 8'h14;
   localparam logic [7:0] MSP_ADDR_STATUS = 8'h18;
   localparam logic [7:0] MSP_ADDR_RESULT = 8'h1C;
   localparam logic [7:0] MSP_ADDR_TXDATA = 8'h20;
   // Offset limits in 0.1 mm
   localparam logic signed [31:0] MSP_OFS_MIN = -32'sd5000000;
   localparam logic signed [31:0] MSP_OFS_MAX = 32'sd5000000;
   localparam logic signed [31:0] MSP_OFS_RST = 32'sd0;
   // Format register fields
   localparam int MSP_FMT_SEL_LSB = 0;
   localparam int MSP_FMT_Q_BIT = 4;
   localparam int MSP_FMT_T_BIT = 5;
   localparam int MSP_FMT_S_BIT = 6;
   localparam int MSP_FMT_TE_LSB = 8;
   localparam int MSP_FMT_SF_BIT = 12;
   localparam logic [2:0] MSP_FMT_MAX = 3'h5;
   localparam logic [3:0] MSP_TE_MIN = 4'h1;
   localparam logic [3:0] MSP_TE_MAX = 4'hA;
   localparam logic [3:0] MSP_TE_RST = 4'h1;
   localparam logic [7:0] MSP_SEP_CHAR = 8'h2C;
   localparam logic [7:0] MSP_UNIT_M = 8'h6D;
   // Line register fields
   localparam int MSP_LINE_BR_LSB = 0;
   localparam int MSP_LINE_SB_LSB = 4;
   localparam int MSP_LINE_RS_LSB = 8;
   localparam logic [3:0] MSP_BR_MAX = 4'hD;
   localparam logic [3:0] MSP_BR_RST = 4'hA;
   localparam logic [1:0] MSP_SB_RST = 2'h1;
   localparam logic [1:0] MSP_RS_RST = 2'h0;
   localparam logic [1:0] MSP_RS_MAX = 2'h2;
   // Command bits
   localparam int MSP_CMD_ZERO = 0;
   localparam int MSP_CMD_RESTORE = 1;
   localparam int MSP_CMD_SEND = 2;
   typedef enum logic [2:0] {
      MSP_FMT_DEC = 3'b000,
      MSP_FMT_DECNS = 3'b001,
      MSP_FMT_FLOAT = 3'b010,
      MSP_FMT_HEX = 3'b011,
      MSP_FMT_BIN = 3'b100,
      MSP_FMT_SYNC = 3'b101
   } msp_fmt_t;
endpackage

// ===== msp_rate_rom.sv
// Baud rate table: select code to rate and divider for the active line
module msp_rate_rom
   import msp_pkg::*;
#(
   parameter int CLK_HZ = 20000000
) (
   input wire logic clk,
   input wire logic [3:0] sel,
   output logic [31:0] rate,
   output logic [15:0] divider
);
   logic [31:0] nxtRate;
   always_comb begin
      case (sel)
         4'h0: nxtRate = 32'd1200;
         4'h1: nxtRate = 32'd2400;
         4'h2: nxtRate = 32'd4800;
         4'h3: nxtRate = 32'd9600;
         4'h4: nxtRate = 32'd14400;
         4'h5: nxtRate = 32'd19200;
         4'h6: nxtRate = 32'd28800;
         4'h7: nxtRate = 32'd38400;
         4'h8: nxtRate = 32'd56000;
         4'h9: nxtRate = 32'd57600;
         4'hA: nxtRate = 32'd115200;
         4'hB: nxtRate = 32'd128000;
         4'hC: nxtRate = 32'd230400;
         4'hD: nxtRate = 32'd256000;
         default: nxtRate = 32'd115200;
      endcase
   end
   always_ff @(posedge clk) begin
      rate <= nxtRate;
      divider <= 16'(CLK_HZ / nxtRate);
   end
endmodule

// ===== msp_core.sv
// Parameter store, offset, zero adjust and output record formatter
// Contract
// - Add signed offset in 0.1 mm, range +-5000000, default 0, to distance.
// - Store any in-range offset exactly as written, no plausibility check.
// - Zero adjust: measure once, store negated result as offset, report it.
// - Format selector 0..5 plus three enable bits, all zero by default.
// - Selector 0 gives prefixed decimal, separator, unit; 1 gives neither.
// - Selector 1 decimal has 'd' prefix, leading zeros, one fraction digit.
// - Selector 2 gives 'h' plus IEEE float hex; 3 gives 'h' plus mm hex.
// - Selector 5 suppresses serial output; only sync interface and switches.
// - Enables add quality, temperature and switch state fields after distance; code can drop only switch state; quality and temperature may overrun 16 bytes.
// - Binary distance: four 7-bit bytes, two's complement, top flag on byte 3.
// - Binary quality: two 7-bit bytes, unsigned, at most 16383.
// - Binary temperature: two 7-bit bytes, sign in bit 14.
// - Separators between values follow the separator selection; code puts a comma before every added field in each ASCII format.
// - Only listed rates 1200..256000 accepted, default 115200, applied at once.
// - Default frame is eight data bits, one stop bit, no parity.
// - Factory restore leaves the baud rate unchanged.
// - Stop bits 0.5, 1.0, 1.5 or 2.0, default 1.0.
// - Exactly one line standard 232, 422 or 485 active, default 232.
// - ASCII records end with selected terminator; code 1 is CR LF; code drops the terminator, or its LF, once the 16-byte record is full.
// - Factory restore keeps rate, stop bits, line standard and fieldbus.
// - Unit appears only when scale multiplier is zero.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
module msp_core
   import msp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic measStart,
   input wire logic measDone,
   input wire logic signed [31:0] measDist,
   output logic signed [31:0] syncDist,
   output logic [2:0] switchOut,
   output logic [15:0] baudDivider,
   output logic [1:0] stopBitCount,
   output logic [2:0] portEnable
);
   logic [7:0] awAddr_ff;
   logic awHave_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   logic wHave_ff;
   logic bValid_ff;
   logic [1:0] bResp_ff;
   logic rValid_ff;
   logic [31:0] rData_ff;
   logic [1:0] rResp_ff;
   logic wrFire;
   logic [31:0] wrVal;
   logic wrOk;
   logic signed [31:0] zeroShift_ff;
   logic [2:0] fmtSel_ff;
   logic qualEn_ff, tempEn_ff, swEn_ff;
   logic [3:0] lineEnd_ff;
   logic multZero_ff;
   logic [3:0] rateSel_ff;
   logic [1:0] stopBits_ff;
   logic [1:0] portStd_ff;
   logic [13:0] quality_ff;
   logic signed [14:0] temp_ff;
   logic [2:0] sw_ff;
   logic zeroBusy_ff, sendBusy_ff;
   logic signed [31:0] result_ff;
   logic [7:0] txBuf_ff [0:15];
   logic [4:0] txLen_ff;
   logic txReady_ff;
   logic [31:0] rate;
   logic signed [31:0] outDist;
   logic [31:0] magDist;
   logic [31:0] floatBits;
   logic [23:0] mmHex;
   logic [7:0] rec [0:15];
   logic [4:0] recLen;
   logic [7:0] bcd [0:6];

   assign s_axi_awready = !awHave_ff && !bValid_ff;
   assign s_axi_wready = !wHave_ff && !bValid_ff;
   assign s_axi_bvalid = bValid_ff;
   assign s_axi_bresp = bResp_ff;
   assign s_axi_arready = !rValid_ff;
   assign s_axi_rvalid = rValid_ff;
   assign s_axi_rdata = rData_ff;
   assign s_axi_rresp = rResp_ff;
   assign wrFire = awHave_ff && wHave_ff && !bValid_ff;
   assign wrVal = wData_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         awHave_ff <= 1'b0;
         wHave_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end else if (wrFire) begin
            awHave_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end else if (wrFire) begin
            wHave_ff <= 1'b0;
         end
      end
   end

   // Writes need all byte lanes; partial writes would split signed values
   always_comb begin
      case (awAddr_ff)
         MSP_ADDR_OFFSET: wrOk = $signed(wrVal) >= MSP_OFS_MIN && $signed(wrVal) <= MSP_OFS_MAX;
         MSP_ADDR_FORMAT, MSP_ADDR_LINE, MSP_ADDR_CMD, MSP_ADDR_MEAS, MSP_ADDR_EXTRA: wrOk = 1'b1;
         default: wrOk = 1'b0;
      endcase
      if (wStrb_ff != 4'hF) wrOk = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bValid_ff <= 1'b0;
         bResp_ff <= 2'h0;
      end else if (wrFire) begin
         bValid_ff <= 1'b1;
         bResp_ff <= wrOk ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         bValid_ff <= 1'b0;
      end
   end

   // Offset: written value kept verbatim, zero adjust stores the negation
   always_ff @(posedge clk) begin
      if (reset) begin
         zeroShift_ff <= MSP_OFS_RST;
      end else if (zeroBusy_ff && measDone) begin
         zeroShift_ff <= -measDist;
      end else if (wrFire && wrOk && awAddr_ff == MSP_ADDR_OFFSET) begin
         zeroShift_ff <= $signed(wrVal);
      end else if (wrFire && wrOk && awAddr_ff == MSP_ADDR_CMD && wrVal[MSP_CMD_RESTORE]) begin
         zeroShift_ff <= MSP_OFS_RST;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || (wrFire && wrOk && awAddr_ff == MSP_ADDR_CMD && wrVal[MSP_CMD_RESTORE])) begin
         fmtSel_ff <= 3'h0;
         qualEn_ff <= 1'b0;
         tempEn_ff <= 1'b0;
         swEn_ff <= 1'b0;
         lineEnd_ff <= MSP_TE_RST;
         multZero_ff <= 1'b1;
      end else if (wrFire && wrOk && awAddr_ff == MSP_ADDR_FORMAT) begin
         if (wrVal[MSP_FMT_SEL_LSB +: 3] <= MSP_FMT_MAX) begin
            fmtSel_ff <= wrVal[MSP_FMT_SEL_LSB +: 3];
         end
         qualEn_ff <= wrVal[MSP_FMT_Q_BIT];
         tempEn_ff <= wrVal[MSP_FMT_T_BIT];
         swEn_ff <= wrVal[MSP_FMT_S_BIT];
         // Invalid terminator codes keep the old one
         if (wrVal[MSP_FMT_TE_LSB +: 4] >= MSP_TE_MIN && wrVal[MSP_FMT_TE_LSB +: 4] <= MSP_TE_MAX) begin
            lineEnd_ff <= wrVal[MSP_FMT_TE_LSB +: 4];
         end
         multZero_ff <= !wrVal[MSP_FMT_SF_BIT];
      end
   end

   // Line settings survive factory restore
   always_ff @(posedge clk) begin
      if (reset) begin
         rateSel_ff <= MSP_BR_RST;
         stopBits_ff <= MSP_SB_RST;
         portStd_ff <= MSP_RS_RST;
      end else if (wrFire && wrOk && awAddr_ff == MSP_ADDR_LINE) begin
         if (wrVal[MSP_LINE_BR_LSB +: 4] <= MSP_BR_MAX) begin
            rateSel_ff <= wrVal[MSP_LINE_BR_LSB +: 4];
         end
         stopBits_ff <= wrVal[MSP_LINE_SB_LSB +: 2];
         if (wrVal[MSP_LINE_RS_LSB +: 2] <= MSP_RS_MAX) begin
            portStd_ff <= wrVal[MSP_LINE_RS_LSB +: 2];
         end
      end
   end

   msp_rate_rom uRate (
      .clk(clk),
      .sel(rateSel_ff),
      .rate(rate),
      .divider(baudDivider)
   );

   assign stopBitCount = stopBits_ff;
   assign portEnable = 3'(3'h1 << portStd_ff);

   always_ff @(posedge clk) begin
      if (reset) begin
         quality_ff <= 14'h0000;
         temp_ff <= 15'h0000;
         sw_ff <= 3'h0;
      end else if (wrFire && wrOk && awAddr_ff == MSP_ADDR_EXTRA) begin
         quality_ff <= wrVal[13:0];
         temp_ff <= wrVal[30:16];
         sw_ff <= {wrVal[15], wrVal[14], wrVal[31]};
      end
   end

   // Measurement sequencing: zero adjust or one formatted record
   always_ff @(posedge clk) begin
      if (reset) begin
         zeroBusy_ff <= 1'b0;
         sendBusy_ff <= 1'b0;
      end else if (measDone) begin
         zeroBusy_ff <= 1'b0;
         sendBusy_ff <= 1'b0;
      end else if (wrFire && wrOk && awAddr_ff == MSP_ADDR_CMD && !zeroBusy_ff && !sendBusy_ff) begin
         zeroBusy_ff <= wrVal[MSP_CMD_ZERO];
         sendBusy_ff <= wrVal[MSP_CMD_SEND] && !wrVal[MSP_CMD_ZERO];
      end
   end
   assign measStart = wrFire && wrOk && awAddr_ff == MSP_ADDR_CMD && !zeroBusy_ff
      && !sendBusy_ff && (wrVal[MSP_CMD_ZERO] || wrVal[MSP_CMD_SEND]);

   assign outDist = measDist + zeroShift_ff;
   assign magDist = outDist[31] ? 32'(-outDist) : outDist;
   // Six hex digits cover the full 500 m range in mm
   assign mmHex = 24'(magDist / 32'd10);

   // Float of the 0.1 mm value; shift count from leading one position
   always_comb begin
      logic [31:0] m;
      int p;
      m = magDist;
      p = 0;
      for (int i = 0; i < 32; i++) begin
         if (m[i]) p = i;
      end
      if (m == 32'h0) floatBits = 32'h0;
      else floatBits = {outDist[31], 8'(127 + p - 0), 23'((m << (31 - p)) >> 8)};
   end

   always_comb begin
      logic [31:0] v;
      v = magDist;
      for (int i = 0; i < 7; i++) begin
         bcd[i] = 8'h30 + 8'(v % 32'd10);
         v = v / 32'd10;
      end
   end

   function automatic logic [7:0] hexChar(input logic [3:0] n);
      hexChar = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   always_comb begin
      int k;
      logic sep;
      k = 0;
      sep = (fmtSel_ff == MSP_FMT_DEC);
      for (int i = 0; i < 16; i++) rec[i] = 8'h00;
      case (fmtSel_ff)
         MSP_FMT_DEC, MSP_FMT_DECNS: begin
            rec[0] = 8'h64;
            rec[1] = bcd[6];
            rec[2] = bcd[5];
            rec[3] = bcd[4];
            rec[4] = bcd[3];
            rec[5] = bcd[2];
            rec[6] = bcd[1];
            rec[7] = 8'h2E;
            rec[8] = bcd[0];
            k = 9;
            if (sep && multZero_ff) begin
               rec[9] = MSP_SEP_CHAR;
               rec[10] = MSP_UNIT_M;
               rec[11] = MSP_UNIT_M;
               k = 12;
            end
         end
         MSP_FMT_FLOAT: begin
            rec[0] = 8'h68;
            for (int i = 0; i < 8; i++) rec[1 + i] = hexChar(floatBits[28 - 4 * i +: 4]);
            k = 9;
         end
         MSP_FMT_HEX: begin
            rec[0] = 8'h68;
            for (int i = 0; i < 6; i++) rec[1 + i] = hexChar(mmHex[(5 - i) * 4 +: 4]);
            k = 7;
         end
         MSP_FMT_BIN: begin
            rec[0] = {1'b1, outDist[27:21]};
            rec[1] = {1'b0, outDist[20:14]};
            rec[2] = {1'b0, outDist[13:7]};
            rec[3] = {1'b0, outDist[6:0]};
            k = 4;
         end
         default: k = 0;
      endcase
      if (fmtSel_ff != MSP_FMT_SYNC) begin
         if (qualEn_ff) begin
            if (fmtSel_ff == MSP_FMT_BIN) begin
               rec[k] = {1'b0, quality_ff[13:7]};
               rec[k + 1] = {1'b0, quality_ff[6:0]};
               k = k + 2;
            end else begin
               rec[k] = MSP_SEP_CHAR;
               for (int i = 0; i < 4; i++) rec[k + 1 + i] = hexChar(4'(quality_ff >> (12 - 4 * i)));
               k = k + 5;
            end
         end
         if (tempEn_ff) begin
            if (fmtSel_ff == MSP_FMT_BIN) begin
               rec[k] = {1'b0, temp_ff[14:8]};
               rec[k + 1] = {1'b0, temp_ff[6:0]};
               k = k + 2;
            end else begin
               rec[k] = MSP_SEP_CHAR;
               rec[k + 1] = hexChar(temp_ff[11:8]);
               rec[k + 2] = hexChar(temp_ff[7:4]);
               k = k + 3;
            end
         end
         if (swEn_ff && k < 15) begin
            if (fmtSel_ff == MSP_FMT_BIN) begin
               rec[k] = {5'h00, sw_ff};
               k = k + 1;
            end else begin
               rec[k] = MSP_SEP_CHAR;
               rec[k + 1] = 8'h30 + {5'h00, sw_ff};
               k = k + 2;
            end
         end
         if (fmtSel_ff != MSP_FMT_BIN && k < 16) begin
            case (lineEnd_ff)
               4'h2: rec[k] = 8'h0D;
               4'h3: rec[k] = 8'h0A;
               4'h4: rec[k] = 8'h02;
               4'h5: rec[k] = 8'h03;
               4'h6: rec[k] = 8'h09;
               4'h7: rec[k] = 8'h20;
               4'h8: rec[k] = 8'h2C;
               4'h9: rec[k] = 8'h3A;
               4'hA: rec[k] = 8'h3B;
               default: rec[k] = 8'h0D;
            endcase
            k = k + 1;
            // Code 1 is CR LF; a full record loses the LF
            if (lineEnd_ff == 4'h1 && k < 16) begin
               rec[k] = 8'h0A;
               k = k + 1;
            end
         end
      end
      recLen = 5'(k);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         result_ff <= 32'sh0;
         txLen_ff <= 5'h00;
         txReady_ff <= 1'b0;
         syncDist <= 32'sh0;
         switchOut <= 3'h0;
         for (int i = 0; i < 16; i++) txBuf_ff[i] <= 8'h00;
      end else if (measDone) begin
         result_ff <= zeroBusy_ff ? -measDist : outDist;
         syncDist <= outDist;
         switchOut <= sw_ff;
         if (sendBusy_ff) begin
            txLen_ff <= recLen;
            txReady_ff <= 1'b1;
            for (int i = 0; i < 16; i++) txBuf_ff[i] <= rec[i];
         end
      end
   end

   // Register reads report current settings
   always_ff @(posedge clk) begin
      if (reset) begin
         rValid_ff <= 1'b0;
         rData_ff <= 32'h0000_0000;
         rResp_ff <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_ff <= 1'b1;
         rResp_ff <= 2'h0;
         case (s_axi_araddr)
            MSP_ADDR_OFFSET: rData_ff <= zeroShift_ff;
            MSP_ADDR_FORMAT: rData_ff <= {19'h0, !multZero_ff, lineEnd_ff, 1'b0, swEn_ff,
               tempEn_ff, qualEn_ff, 1'b0, fmtSel_ff};
            MSP_ADDR_LINE: rData_ff <= {22'h0, portStd_ff, 2'h0, stopBits_ff, rateSel_ff};
            MSP_ADDR_STATUS: rData_ff <= {26'h0, txLen_ff, txReady_ff} | {zeroBusy_ff, sendBusy_ff, 30'h0};
            MSP_ADDR_RESULT: rData_ff <= result_ff;
            MSP_ADDR_TXDATA: rData_ff <= rate;
            default: begin
               rData_ff <= 32'h0000_0000;
               rResp_ff <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   zero_adjust_a: assert property (@(posedge clk) disable iff (reset)
      zeroBusy_ff && measDone |=> zeroShift_ff == -$past(measDist))
      else $error("zero adjust did not store negated distance");
   offset_range_a: assert property (@(posedge clk) disable iff (reset)
      wrFire && awAddr_ff == MSP_ADDR_OFFSET && !(zeroBusy_ff && measDone)
      && ($signed(wrVal) < MSP_OFS_MIN || $signed(wrVal) > MSP_OFS_MAX)
      |=> $stable(zeroShift_ff))
      else $error("offset out of range was stored");
   restore_rate_a: assert property (@(posedge clk) disable iff (reset)
      wrFire && awAddr_ff == MSP_ADDR_CMD |=> $stable(rateSel_ff))
      else $error("restore changed rate");
   port_onehot_a: assert property (@(posedge clk) disable iff (reset)
      $onehot(portEnable))
      else $error("line standard not exclusive");
   format_range_a: assert property (@(posedge clk) disable iff (reset)
      fmtSel_ff <= MSP_FMT_MAX)
      else $error("format selector beyond 5");
   bin_flag_a: assert property (@(posedge clk) disable iff (reset)
      fmtSel_ff == MSP_FMT_BIN |-> rec[0][7] && !rec[1][7] && !rec[3][7])
      else $error("binary distance flag bits wrong");
   sync_quiet_a: assert property (@(posedge clk) disable iff (reset)
      fmtSel_ff == MSP_FMT_SYNC |-> recLen == 5'h00)
      else $error("serial record in sync mode");
   term_end_a: assert property (@(posedge clk) disable iff (reset)
      fmtSel_ff <= MSP_FMT_HEX && lineEnd_ff == 4'h2 && recLen != 5'h00
      && recLen <= 5'd16 |-> rec[4'(recLen - 5'd1)] == 8'h0D)
      else $error("terminator missing");
   cover_zero: cover property (@(posedge clk) zeroBusy_ff && measDone);
   cover_send: cover property (@(posedge clk) sendBusy_ff && measDone);
   cover_restore: cover property (@(posedge clk)
      wrFire && awAddr_ff == MSP_ADDR_CMD && wrVal[MSP_CMD_RESTORE]);
endmodule

// ===== msp_meas_model.sv
// Measurement engine model answering one request with one distance
module msp_meas_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic measStart,
   input wire logic signed [31:0] nextDist,
   input wire logic [7:0] lat,
   output logic measDone,
   output logic signed [31:0] measDist
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy = 1'b0;
   logic [7:0] cnt = 8'h00;
   initial measDone = 1'b0;
   initial measDist = 32'sh0;
   // Distance is only valid with done, so it toggles otherwise
   always @(posedge clk) begin
      measDone <= 1'b0;
      measDist <= ~measDist;
      if (reset) begin
         busy <= 1'b0;
      end else if (measStart && !busy) begin
         busy <= 1'b1;
         cnt <= lat;
      end else if (busy && cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else if (busy) begin
         busy <= 1'b0;
         measDone <= 1'b1;
         measDist <= nextDist;
      end
   end
endmodule

// ===== test_meter_serial_param_output.sv
// Self-checking bench for offset, format and line settings
module test_meter_serial_param_output;
   timeunit 1ns;
   timeprecision 1ns;
   import msp_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, lat = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, measStart, measDone;
   logic [1:0] bresp, rresp, stopBitCount;
   logic signed [31:0] measDist, syncDist, nextDist = 32'sh0;
   logic [2:0] switchOut, portEnable;
   logic [15:0] baudDivider;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int miscompares = 0, total_checks = 0, cyc = 0;
   logic [31:0] rates[14] = '{32'd1200, 32'd2400, 32'd4800, 32'd9600, 32'd14400, 32'd19200,
      32'd28800, 32'd38400, 32'd56000, 32'd57600, 32'd115200, 32'd128000, 32'd230400, 32'd256000};
   always #25 clk = ~clk;
   msp_core uut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .measStart(measStart), .measDone(measDone), .measDist(measDist), .syncDist(syncDist),
      .switchOut(switchOut), .baudDivider(baudDivider), .stopBitCount(stopBitCount),
      .portEnable(portEnable));
   msp_meas_model model (.clk(clk), .reset(reset), .measStart(measStart), .nextDist(nextDist),
      .lat(lat), .measDone(measDone), .measDist(measDist));
   task cmp(input logic [33:0] g, input logic [33:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task end_sim;
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   // Error responses carry no meaningful data
   always @(posedge clk) begin
      if (bvalid) cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (rvalid) cmp({rresp, rresp == 2'h0 ? rdata : 32'h0}, rq.pop_front());
   end
   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bq.push_back(er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask
   task axr(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
   endtask
   task waitMeas;
      do @(posedge clk); while (measDone !== 1'b1);
      repeat (2) @(posedge clk);
   endtask
   initial begin
      logic [31:0] o, e;
      o = $urandom(32'h6DC3);
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      axr(MSP_ADDR_OFFSET, 34'h0);
      axr(MSP_ADDR_FORMAT, 34'h100);
      axr(MSP_ADDR_LINE, 34'h1A);
      axr(MSP_ADDR_TXDATA, {2'h0, rates[10]});
      for (int i = 0; i < 3; i++) begin
         o = i == 0 ? MSP_OFS_MIN : i == 1 ? MSP_OFS_MAX : $urandom_range(10000000) - 5000000;
         axw(MSP_ADDR_OFFSET, o, 2'h0);
         axr(MSP_ADDR_OFFSET, {2'h0, o});
      end
      axw(MSP_ADDR_OFFSET, MSP_OFS_MAX + 1, 2'h2);
      axr(MSP_ADDR_OFFSET, {2'h0, o});
      nextDist <= 32'sd1234;
      lat <= 8'd3;
      axw(MSP_ADDR_CMD, 32'h4, 2'h0);
      waitMeas();
      cmp({2'h0, syncDist}, {2'h0, 32'(o + 32'd1234)});
      // Decimal with unit: 12 bytes plus CR LF, record ready
      axr(MSP_ADDR_STATUS, 34'h1D);
      nextDist <= 32'sd21091;
      lat <= 8'd40;
      axw(MSP_ADDR_CMD, 32'h1, 2'h0);
      waitMeas();
      axr(MSP_ADDR_OFFSET, {2'h0, 32'(-32'sd21091)});
      axr(MSP_ADDR_RESULT, {2'h0, 32'(-32'sd21091)});
      for (int s = 0; s < 8; s++) begin
         e = {20'h0, 4'h2, 1'b0, 3'(s), 1'b0, s > 5 ? 3'h5 : 3'(s)};
         axw(MSP_ADDR_FORMAT, {20'h0, 4'h2, 1'b0, 3'(s), 1'b0, 3'(s)}, 2'h0);
         axr(MSP_ADDR_FORMAT, {2'h0, e});
      end
      // Every rate code plus invalid code 14, with divider, stop bits and line standard
      for (int i = 0; i < 15; i++) begin
         axw(MSP_ADDR_LINE, {22'h0, 2'(i % 3), 2'h0, 2'(i % 4), 4'(i)}, 2'h0);
         e = rates[i > 13 ? 13 : i];
         axr(MSP_ADDR_TXDATA, {2'h0, e});
         cmp({18'h0, baudDivider}, {18'h0, 16'(32'd20000000 / e)});
         cmp({32'h0, stopBitCount}, 34'(i % 4));
         cmp({31'h0, portEnable}, 34'(1 << (i % 3)));
      end
      axw(MSP_ADDR_CMD, 32'h2, 2'h0);
      repeat (2) @(posedge clk);
      axr(MSP_ADDR_FORMAT, 34'h100);
      axr(MSP_ADDR_OFFSET, 34'h0);
      axr(MSP_ADDR_LINE, 34'h22D);
      // Binary record with every field: 4 + 2 + 2 + 1 bytes
      e = $urandom();
      axw(MSP_ADDR_EXTRA, e, 2'h0);
      axw(MSP_ADDR_FORMAT, 32'h174, 2'h0);
      nextDist <= $urandom();
      axw(MSP_ADDR_CMD, 32'h4, 2'h0);
      waitMeas();
      cmp({31'h0, switchOut}, {31'h0, e[15], e[14], e[31]});
      axr(MSP_ADDR_STATUS, 34'h13);
      axr(MSP_ADDR_RESULT, {2'h0, nextDist});
      // Sync mode leaves an empty serial record
      axw(MSP_ADDR_FORMAT, 32'h175, 2'h0);
      axw(MSP_ADDR_CMD, 32'h4, 2'h0);
      waitMeas();
      cmp({2'h0, syncDist}, {2'h0, nextDist});
      axr(MSP_ADDR_STATUS, 34'h1);
      axr(8'h24, {2'h2, 32'h0});
      axr(MSP_ADDR_CMD, {2'h2, 32'h0});
      axw(8'h24, 32'h0, 2'h2);
      repeat (2) @(posedge clk);
      end_sim();
   end
endmodule
